// file: bc_txgen_pkg.sv
// Shared constants, field layouts and carrier types of the BC transmit data generator.
// Assumes a single pclk domain and APB register access.
`default_nettype none

package bc_txgen_pkg;

    // ********************************************
    // Sizes
    // ********************************************
    localparam int unsigned N_FIFO    = 32;
    localparam int unsigned FIFO_BUFS = 128;
    localparam int unsigned BUF_WORDS = 32;
    localparam int unsigned N_DSET    = 4095;
    localparam int unsigned N_FUNC    = 2;
    localparam int unsigned N_TAG     = 4;
    localparam int unsigned N_SLOT    = N_FUNC + N_TAG;
    localparam int unsigned MSG_AW    = 12;
    localparam int unsigned SHM_AW    = 18;
    localparam int unsigned PAW       = 8;

    // ********************************************
    // Register offsets
    // ********************************************
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_XFER     = 8'h04;
    localparam logic [7:0] OFF_DSET     = 8'h08;
    localparam logic [7:0] OFF_FUNC0    = 8'h0C;
    localparam logic [7:0] OFF_TAG0     = 8'h14;
    localparam logic [7:0] OFF_MEMADDR  = 8'h24;
    localparam logic [7:0] OFF_MEMDATA  = 8'h28;
    localparam logic [7:0] OFF_FIFOCMD  = 8'h2C;
    localparam logic [7:0] OFF_FIFOSTAT = 8'h30;
    localparam logic [7:0] OFF_STATUS   = 8'h34;

    // ********************************************
    // Reset values and fixed words
    // ********************************************
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;
    localparam logic [7:0]  PTR_ZERO  = 8'h00;
    localparam logic [4:0]  LAST_WORD = 5'h1F;
    localparam logic [2:0]  LAST_SLOT = 3'h5;

    // ********************************************
    // Types
    // ********************************************
    typedef enum logic [1:0] {SRC_FIXED = 2'h0, SRC_FIFO = 2'h1, SRC_DSET = 2'h2} src_t;

    typedef enum logic [2:0] {
        FN_RAMP_UP = 3'h0, FN_RAMP_DN = 3'h1, FN_TRI_UP = 3'h2, FN_TRI_DN = 3'h3, FN_COPY = 3'h4
    } func_kind_t;

    typedef enum logic [1:0] {TW_WORD = 2'h0, TW_LSB = 2'h1, TW_MSB = 2'h2} tag_width_t;

    typedef struct packed {
        logic [10:0] rsvd;
        logic [4:0]  src_word;
        logic [6:0]  src_buf;
        logic [4:0]  word_pos;
        func_kind_t  kind;
        logic        en;
    } func_cfg_t;

    typedef struct packed {
        logic [15:0] init;
        logic [6:0]  rsvd;
        logic [4:0]  word_pos;
        logic        load;
        tag_width_t  width;
        logic        en;
    } tag_cfg_t;

    typedef struct packed {
        logic              we;
        logic [SHM_AW-1:0] addr;
        logic [15:0]       wdata;
    } shm_req_t;

    typedef struct packed {
        logic              we;
        logic [MSG_AW-1:0] addr;
        logic [15:0]       wdata;
    } msg_req_t;

endpackage

`default_nettype wire

// file: word_ram.sv
// Single-port word memory with registered read data.
// Assumes one request per cycle; read data appear one edge after the address.
`default_nettype none

module word_ram #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    // Clock
    input  wire logic          clk,
    // Request
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    // Answer
    output var  logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[addr] <= wdata;
        rdata <= mem[addr];
    end

endmodule

`default_nettype wire

// file: dyn_word_gen.sv
// Next-value logic for one function or tagging slot.
// Assumes the caller stores the returned state and writes the word.
`default_nettype none

module dyn_word_gen
    import bc_txgen_pkg::*;
(
    // Slot configuration
    input  wire logic        is_tag,
    input  wire func_kind_t  kind,
    input  wire tag_width_t  width,
    input  wire logic        load,
    input  wire logic [15:0] init,
    // Slot state and stored word
    input  wire logic [15:0] fval,
    input  wire logic        fdir,
    input  wire logic [15:0] rd_data,
    // Results
    output logic      [15:0] word,
    output logic      [15:0] nval,
    output logic             ndir
);

    wire logic [15:0] base   = load ? init : rd_data;
    wire logic [15:0] up     = fval + 16'h0001;
    wire logic [15:0] dn     = fval - 16'h0001;
    wire logic        at_top = fval == WORD_ONES;
    wire logic        at_bot = fval == WORD_ZERO;

    always_comb
    begin
        nval = fval;
        ndir = fdir;
        word = rd_data;
        if (is_tag)
        begin
            unique case (width)
                TW_LSB:  word = {base[15:8], 8'(base[7:0] + 8'h01)};
                TW_MSB:  word = {8'(base[15:8] + 8'h01), base[7:0]};
                default: word = base + 16'h0001;
            endcase
        end
        else
        begin
            unique case (kind)
                FN_RAMP_UP: nval = up;
                FN_RAMP_DN: nval = dn;
                FN_TRI_UP, FN_TRI_DN:
                begin
                    // Turn at the rails so the wave never wraps
                    if (fdir)
                    begin
                        nval = at_top ? dn : up;
                        ndir = ~at_top;
                    end
                    else
                    begin
                        nval = at_bot ? up : dn;
                        ndir = at_bot;
                    end
                end
                default: nval = fval;
            endcase
            if (kind != FN_COPY)
                word = nval;
        end
    end

endmodule

`default_nettype wire

// file: bc_txgen.sv
// BC transmit data generator: APB slave, message buffer and shared memory,
// and the sequencer that refreshes one message buffer per executed transfer.
// Assumes a single pclk domain; host software owns buffer contents and FIFO refill.
`default_nettype none

module bc_txgen
    import bc_txgen_pkg::*;
(
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB request
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [PAW-1:0] paddr,
    input  wire logic [31:0]    pwdata,
    // APB answer
    output var  logic [31:0]    prdata,
    output var  logic           pready,
    output var  logic           pslverr
);

    // ********************************************
    // State and registers
    // ********************************************
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_COPY = 3'b010, ST_DYN = 3'b100} state_t;

    state_t      state_q;
    logic [4:0]  cnt_q;
    logic        ph_q;
    logic        rd_issued_q;
    src_t        src_q;
    logic [6:0]  msg_buf_q;
    logic [4:0]  fifo_sel_q;
    logic [4:0]  stat_sel_q;
    logic [11:0] dset_q;
    func_cfg_t   func_q [N_FUNC];
    logic [15:0] fval_q [N_FUNC];
    logic        fdir_q [N_FUNC];
    tag_cfg_t    tag_q  [N_TAG];
    logic        tload_q [N_TAG];
    logic [7:0]  fifo_wr_q [N_FIFO];
    logic [7:0]  fifo_rd_q [N_FIFO];
    logic        win_shm_q;
    logic [17:0] win_addr_q;
    logic        underflow_q;
    logic [15:0] exec_cnt_q;

    // ********************************************
    // APB decode
    // ********************************************
    wire logic       idle      = state_q == ST_IDLE;
    wire logic       acc       = psel & penable & ~pready;
    wire logic [5:0] widx      = paddr[7:2];
    wire logic       hit_ctrl  = paddr == OFF_CTRL;
    wire logic       hit_xfer  = paddr == OFF_XFER;
    wire logic       hit_dset  = paddr == OFF_DSET;
    wire logic       hit_func  = paddr >= OFF_FUNC0 && paddr < OFF_TAG0;
    wire logic       hit_tag   = paddr >= OFF_TAG0 && paddr < OFF_MEMADDR;
    wire logic       hit_maddr = paddr == OFF_MEMADDR;
    wire logic       hit_mdata = paddr == OFF_MEMDATA;
    wire logic       hit_fcmd  = paddr == OFF_FIFOCMD;
    wire logic       hit_fstat = paddr == OFF_FIFOSTAT;
    wire logic       hit_stat  = paddr == OFF_STATUS;
    wire logic       aligned   = paddr[1:0] == 2'b00;
    wire logic       mapped    = aligned & (hit_ctrl | hit_xfer | hit_dset | hit_func | hit_tag
                                 | hit_maddr | hit_mdata | hit_fcmd | hit_fstat | hit_stat);
    wire logic       fidx      = 1'(widx - 6'(OFF_FUNC0 >> 2));
    wire logic [1:0] tidx      = 2'(widx - 6'(OFF_TAG0 >> 2));
    // Memory window stalls while the sequencer owns the memories
    wire logic       mem_acc   = mapped & hit_mdata;
    wire logic       rd_issue  = acc & mem_acc & ~pwrite & idle & ~rd_issued_q;
    wire logic       done      = acc & (~mem_acc | (pwrite & idle) | rd_issued_q);
    wire logic       wr_fire   = done & pwrite & mapped;
    wire logic       exec      = wr_fire & hit_ctrl & pwdata[0] & idle;

    wire logic [7:0] sel_level  = 8'(fifo_wr_q[fifo_sel_q] - fifo_rd_q[fifo_sel_q]);
    wire logic [7:0] stat_level = 8'(fifo_wr_q[stat_sel_q] - fifo_rd_q[stat_sel_q]);

    // ********************************************
    // Memories and slot generator
    // ********************************************
    logic [15:0] shm_rdata;
    logic [15:0] msg_rdata;
    shm_req_t    shm_req;
    msg_req_t    msg_req;

    word_ram #(.AW(SHM_AW), .DW(16)) u_shm (
        .clk   (pclk),
        .we    (shm_req.we),
        .addr  (shm_req.addr),
        .wdata (shm_req.wdata),
        .rdata (shm_rdata)
    );

    word_ram #(.AW(MSG_AW), .DW(16)) u_msg (
        .clk   (pclk),
        .we    (msg_req.we),
        .addr  (msg_req.addr),
        .wdata (msg_req.wdata),
        .rdata (msg_rdata)
    );

    wire logic [2:0]  slot     = cnt_q[2:0];
    wire logic        is_tag   = slot >= 3'(N_FUNC);
    wire logic        sf       = slot[0];
    wire logic [1:0]  st       = 2'(slot - 3'(N_FUNC));
    wire func_cfg_t   fc       = func_q[sf];
    wire tag_cfg_t    tc       = tag_q[st];
    wire logic        slot_en  = is_tag ? tc.en : fc.en;
    wire logic [4:0]  slot_pos = is_tag ? tc.word_pos : fc.word_pos;
    wire logic        is_copy  = ~is_tag & fc.kind == FN_COPY;
    wire logic [6:0]  rd_buf   = is_copy ? fc.src_buf : msg_buf_q;
    wire logic [4:0]  rd_word  = is_copy ? fc.src_word : slot_pos;
    wire logic [15:0] gen_word;
    wire logic [15:0] gen_val;
    wire logic        gen_dir;

    dyn_word_gen u_gen (
        .is_tag  (is_tag),
        .kind    (fc.kind),
        .width   (tc.width),
        .load    (tload_q[st]),
        .init    (tc.init),
        .fval    (fval_q[sf]),
        .fdir    (fdir_q[sf]),
        .rd_data (msg_rdata),
        .word    (gen_word),
        .nval    (gen_val),
        .ndir    (gen_dir)
    );

    // FIFO area first, dataset pool above it
    wire logic [17:0] fifo_addr = {1'b0, fifo_sel_q, fifo_rd_q[fifo_sel_q][6:0], cnt_q};
    wire logic [17:0] dset_addr = {1'b1, dset_q, cnt_q};
    wire logic        copy_wr   = state_q == ST_COPY & ph_q;
    wire logic        dyn_wr    = state_q == ST_DYN & ph_q & slot_en;
    wire logic        win_we    = wr_fire & mem_acc;
    wire logic        win_go    = win_we | rd_issue;

    assign shm_req.we    = win_we & win_shm_q;
    assign shm_req.addr  = state_q == ST_COPY ? (src_q == SRC_FIFO ? fifo_addr : dset_addr)
                                              : win_addr_q;
    assign shm_req.wdata = pwdata[15:0];
    assign msg_req.we    = copy_wr | dyn_wr | (win_we & ~win_shm_q);
    assign msg_req.addr  = copy_wr ? {msg_buf_q, cnt_q}
                         : state_q == ST_DYN ? (ph_q ? {msg_buf_q, slot_pos} : {rd_buf, rd_word})
                         : win_addr_q[MSG_AW-1:0];
    assign msg_req.wdata = copy_wr ? shm_rdata : state_q == ST_DYN ? gen_word : pwdata[15:0];

    // ********************************************
    // Read mux
    // ********************************************
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_xfer)
            rd_mux = {14'h0000, src_q, 3'h0, fifo_sel_q, 1'b0, msg_buf_q};
        else if (hit_dset)
            rd_mux = {20'h00000, dset_q};
        else if (hit_func)
            rd_mux = func_q[fidx];
        else if (hit_tag)
            rd_mux = tag_q[tidx];
        else if (hit_maddr)
            rd_mux = {win_shm_q, 13'h0000, win_addr_q};
        else if (hit_mdata)
            rd_mux = {16'h0000, win_shm_q ? shm_rdata : msg_rdata};
        else if (hit_fcmd)
            rd_mux = {27'h0000000, stat_sel_q};
        else if (hit_fstat)
            rd_mux = {24'h000000, stat_level};
        else if (hit_stat)
            rd_mux = {exec_cnt_q, 14'h0000, underflow_q, ~idle};
    end

    // ********************************************
    // APB answer
    // ********************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0000_0000;
            rd_issued_q <= 1'b0;
        end
        else
        begin
            pready      <= done;
            pslverr     <= done & ~mapped;
            prdata      <= done & ~pwrite & mapped ? rd_mux : 32'h0000_0000;
            rd_issued_q <= rd_issue;
        end
    end

    // ********************************************
    // Configuration registers
    // ********************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_q      <= SRC_FIXED;
            msg_buf_q  <= 7'h00;
            fifo_sel_q <= 5'h00;
            stat_sel_q <= 5'h00;
            dset_q     <= 12'h000;
            win_shm_q  <= 1'b0;
            win_addr_q <= 18'h00000;
        end
        else
        begin
            if (wr_fire & hit_xfer & idle)
            begin
                msg_buf_q  <= pwdata[6:0];
                fifo_sel_q <= pwdata[12:8];
                src_q      <= src_t'(pwdata[17:16]);
            end
            if (wr_fire & hit_dset & idle)
                dset_q <= pwdata[11:0];
            if (wr_fire & hit_fcmd)
                stat_sel_q <= pwdata[4:0];
            // Auto-increment lets software stream a whole buffer
            if (wr_fire & hit_maddr)
            begin
                win_shm_q  <= pwdata[31];
                win_addr_q <= pwdata[17:0];
            end
            else if (done & mem_acc)
                win_addr_q <= win_addr_q + 18'h00001;
        end
    end

    // ********************************************
    // Sequencer
    // ********************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q     <= ST_IDLE;
            cnt_q       <= 5'h00;
            ph_q        <= 1'b0;
            underflow_q <= 1'b0;
            exec_cnt_q  <= WORD_ZERO;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            if (exec & src_q == SRC_FIFO & sel_level == PTR_ZERO)
                underflow_q <= 1'b1;
            else if (wr_fire & hit_stat & pwdata[1])
                underflow_q <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= 5'h00;
                    ph_q  <= 1'b0;
                    // Empty FIFO leaves the previous buffer contents in place
                    if (exec)
                        state_q <= (src_q == SRC_DSET
                                    || (src_q == SRC_FIFO && sel_level != PTR_ZERO))
                                   ? ST_COPY : ST_DYN;
                end
                ST_COPY:
                begin
                    ph_q <= ~ph_q;
                    if (ph_q)
                        cnt_q <= cnt_q + 5'h01;
                    if (ph_q && cnt_q == LAST_WORD)
                        state_q <= ST_DYN;
                end
                ST_DYN:
                begin
                    ph_q <= ~ph_q;
                    if (ph_q)
                        cnt_q <= cnt_q + 5'h01;
                    if (ph_q && slot == LAST_SLOT)
                    begin
                        state_q    <= ST_IDLE;
                        exec_cnt_q <= exec_cnt_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // ********************************************
    // Per-slot state and FIFO pointers
    // ********************************************
    wire logic copy_last = copy_wr & cnt_q == LAST_WORD & src_q == SRC_FIFO;

    genvar g;
    generate
        for (g = 0; g < N_FIFO; g++)
        begin : g_fifo
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    fifo_wr_q[g] <= PTR_ZERO;
                    fifo_rd_q[g] <= PTR_ZERO;
                end
                else
                begin
                    if (wr_fire & hit_fcmd & pwdata[4:0] == 5'(g))
                        fifo_wr_q[g] <= fifo_wr_q[g] + pwdata[15:8];
                    if (copy_last & fifo_sel_q == 5'(g))
                        fifo_rd_q[g] <= fifo_rd_q[g] + 8'h01;
                end
            end
        end
        for (g = 0; g < N_FUNC; g++)
        begin : g_func
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    func_q[g] <= '0;
                    fval_q[g] <= WORD_ZERO;
                    fdir_q[g] <= 1'b1;
                end
                else if (wr_fire & hit_func & fidx == 1'(g) & idle)
                begin
                    // Falling kinds (kind bit 0 set) start at the top rail, heading down
                    func_q[g] <= func_cfg_t'(pwdata);
                    fval_q[g] <= pwdata[1] ? WORD_ONES : WORD_ZERO;
                    fdir_q[g] <= ~pwdata[1];
                end
                else if (dyn_wr & ~is_tag & sf == 1'(g))
                begin
                    fval_q[g] <= gen_val;
                    fdir_q[g] <= gen_dir;
                end
            end
        end
        for (g = 0; g < N_TAG; g++)
        begin : g_tag
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    tag_q[g]   <= '0;
                    tload_q[g] <= 1'b0;
                end
                else if (wr_fire & hit_tag & tidx == 2'(g) & idle)
                begin
                    tag_q[g]   <= tag_cfg_t'(pwdata);
                    tload_q[g] <= pwdata[3];
                end
                else if (dyn_wr & is_tag & st == 2'(g))
                    tload_q[g] <= 1'b0;
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: host_fill_model.sv
// Host side image of one fixed transmit buffer word.
// Assumes a bench that reads one word per index.
`default_nettype none

module host_fill_model (
    // Index and word
    input  wire logic [4:0]  idx,
    output logic      [15:0] word
);
    // Two words sit at a byte wrap so both byte counters wrap to 00 with no carry
    assign word = (idx == 5'h05) ? 16'h12FF :
                  (idx == 5'h06) ? 16'hFF34 : {11'h500, idx};
endmodule

`default_nettype wire

// file: bc_txgen_monitor.sv
// Checker of the APB answer of bc_txgen.
// Assumes binding to the ports of bc_txgen.
`default_nettype none

module bc_txgen_monitor
    import bc_txgen_pkg::*;
(
    // Clock, reset and APB
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [PAW-1:0] paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [31:0]    prdata,
    input  wire logic           pready,
    input  wire logic           pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without access");
    // Busy execute bounds the wait: 76 cycles plus two
    answer_bound_a: assert property (psel && $rose(penable) |-> ##[1:90] pready)
        else $error("no answer");
    err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned ok");
    unmapped_err_a: assert property (pready && paddr > OFF_STATUS |-> pslverr)
        else $error("unmapped ok");
    word_window_a: assert property (pready && !pwrite && paddr == OFF_MEMDATA
        |-> prdata[31:16] == 16'h0 && !pslverr) else $error("window upper");
endmodule

bind bc_txgen bc_txgen_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

`default_nettype wire

// file: bc_txgen_bench.sv
// Self-checking bench of bc_txgen over APB.
// Assumes host_fill_model and the bound checker.
`default_nettype none

module bc_txgen_bench
    import bc_txgen_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr;
    logic [15:0] img [32], rnd [32], ex [32];
    logic [64:0] q [$];
    int          err_total = 0, comparisons = 0;

    bc_txgen i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    for (genvar g = 0; g < 32; g++)
    begin : g_img
        host_fill_model i_host (.idx(5'(g)), .word(img[g]));
    end

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    task automatic final_report();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask

    // Oldest note pairs with each answer
    always @(posedge pclk)
    begin
        logic [64:0] t;
        if (psel && penable && pready === 1'b1 && q.size() > 0)
        begin
            t = q.pop_front();
            if (t[64:33] != 32'h0)
                cmp_word("prdata", t[32:1], prdata & t[64:33]);
            cmp_word("pslverr", {31'h0, t[0]}, {31'h0, pslverr});
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic se);
        int n;
        q.push_back({m, e, se});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 200)
        begin
            err_total++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, m, e, 1'b0);
    endtask

    // Execute, then poll busy; new executes are dropped while busy
    task automatic run();
        int k;
        wr(OFF_CTRL, 32'h1);
        k = 0;
        rd(OFF_STATUS, 32'h0, 32'h0);
        while (r[0] !== 1'b0 && k < 40)
        begin
            rd(OFF_STATUS, 32'h0, 32'h0);
            k++;
        end
        if (k >= 40)
        begin
            err_total++;
            final_report();
        end
    endtask

    task automatic mem_wr(input logic [31:0] adr, input logic [15:0] v [32]);
        wr(OFF_MEMADDR, adr);
        foreach (v[i]) wr(OFF_MEMDATA, {16'h0, v[i]});
    endtask

    task automatic mem_chk(input int n, input logic [15:0] v [32]);
        wr(OFF_MEMADDR, 32'h20);
        for (int i = 0; i < n; i++) rd(OFF_MEMDATA, 32'hFFFF, {16'h0, v[i]});
    endtask

    initial
    begin
        void'($urandom(58));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_STATUS, 32'hFFFFFFFF, 32'h0);
        mem_wr(32'h20, img);
        wr(OFF_FUNC0, 32'h21);
        wr(OFF_FUNC0 + 8'h04, 32'h33);
        wr(OFF_TAG0, 32'h12340049);
        wr(OFF_TAG0 + 8'h04, 32'h53);
        wr(OFF_TAG0 + 8'h08, 32'h65);
        wr(OFF_XFER, 32'h1);
        run();
        run();
        // Falling ramp starts at the top rail: FFFE, then FFFD
        ex = img;
        ex[2:6] = '{16'h0002, 16'hFFFD, 16'h1236, 16'h1201, 16'h0134};
        mem_chk(8, ex);
        for (int i = 0; i < 6; i++) wr(OFF_FUNC0 + 8'(4 * i), 32'h0);
        foreach (rnd[i]) rnd[i] = 16'($urandom);
        mem_wr(32'h80003000, rnd);
        wr(OFF_FIFOCMD, 32'h103);
        rd(OFF_FIFOSTAT, 32'hFF, 32'h1);
        wr(OFF_XFER, 32'h10301);
        run();
        mem_chk(32, rnd);
        rd(OFF_FIFOSTAT, 32'hFF, 32'h0);
        run();
        mem_chk(32, rnd);
        rd(OFF_STATUS, 32'h3, 32'h2);
        wr(OFF_STATUS, 32'h2);
        rd(OFF_STATUS, 32'h3, 32'h0);
        foreach (rnd[i]) rnd[i] = 16'($urandom);
        mem_wr(32'h8003FFC0, rnd);
        wr(OFF_DSET, 32'hFFE);
        wr(OFF_XFER, 32'h20001);
        run();
        mem_chk(32, rnd);
        // Falling triangle in slot 0, slot 1 copies the word slot 0 just wrote
        wr(OFF_XFER, 32'h1);
        wr(OFF_FUNC0, 32'h77);
        wr(OFF_FUNC0 + 8'h04, 32'h70289);
        run();
        ex = rnd;
        ex[7:8] = '{16'hFFFE, 16'hFFFE};
        mem_chk(9, ex);
        rd(OFF_STATUS, 32'hFFFF0000, 32'h00060000);
        apb(1'b0, 8'h3C, 32'h0, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h05, 32'h0, 32'h0, 32'h0, 1'b1);
        @(posedge pclk);
        final_report();
    end
endmodule

`default_nettype wire
